// ===== rtl/sdram_command_timing_guard.sv
// host-side sdram command issuer that keeps every command spacing
`timescale 1ns/1ps
`include "sdram_timing_defs.svh"
// Functional notes
// - keep row cycle between refreshes and between same-bank activates
// - precharge no sooner than activate-to-precharge minimum, never past maximum
// - after precharge wait the precharge period before activating that bank
// - wait activate-to-column delay before read or write
// - separate activates to different banks by bank-to-bank gap
// - wait one clock after last write data before precharge
// - write with auto precharge: one clock plus precharge before next activate
// - issue 4096 refreshes in every 64 ms
// - after raising clock enable wait one clock plus 3 ns
// - hold off memory operation 100 us after power-up
// - run full initialization before any activate, read or write
// - no command for 2 clocks after mode register load
// - no command while an auto-refresh runs its row cycle
// - precharge with all-bank bit high closes both banks
module sdram_command_timing_guard #(
  parameter int PWR_CYC = `T_PWR_CYC,
  parameter int REFI_CYC = `T_REFI_CYC,
  parameter int RAS_MAX_CYC = `T_RAS_MAX_CYC,
  parameter int CW = `CNT_W
) (
  input wire logic i_ref_clk,                   // system clock
  input wire logic i_rst_b,                     // async reset, active low
  input wire logic i_ce,                        // freezes state when low
  input wire logic i_req_valid,                 // request offered
  input wire sdram_guard_pkg::req_op_t i_req_op, // request kind
  input wire logic i_req_bank,                  // target bank
  input wire logic [`ADDR_W-1:0] i_req_addr,    // row, column, ap/all bit
  input wire logic [`DQ_W-1:0] i_req_wdata,     // write data
  input wire logic [1:0] i_req_wmask,           // write byte masks
  output logic o_req_ready,                     // request taken
  output logic o_init_done,                     // initialization finished
  output logic o_rd_valid,                      // read data pulse
  output logic [`DQ_W-1:0] o_rd_data,           // read data
  output logic o_cke,                           // clock enable pin
  output logic o_cs_b,                          // chip select pin
  output logic o_ras_b,                         // row strobe pin
  output logic o_cas_b,                         // column strobe pin
  output logic o_we_b,                          // write enable pin
  output logic [`ADDR_W-1:0] o_addr,            // address pins incl all_bank_select_bit
  output logic o_bank_address_bit,              // bank select pin
  output logic [1:0] o_dqm,                     // byte mask pins
  output logic [`DQ_W-1:0] o_dq,                // data pin output
  output logic o_dq_oe_b,                       // data pin drive, low drives
  input wire logic [`DQ_W-1:0] i_dq             // data pin input
);
  localparam int TRC_C = `T_RC_CYC;
  localparam int TRRD_C = `T_RRD_CYC;
  localparam int TCKA_C = `T_CKA_CYC;
  localparam int TMRD_C = `T_MRD_CYC;
  localparam int TAP = `RD_TAP;
  localparam logic [CW-1:0] L_RC = CW'(TRC_C - 1);
  localparam logic [CW-1:0] L_RP = CW'(`T_RP_CYC - 1);
  localparam logic [CW-1:0] L_RRD = CW'(TRRD_C - 1);
  localparam logic [CW-1:0] L_CKA = CW'(TCKA_C - 1);
  localparam logic [CW-1:0] L_MRD = CW'(TMRD_C - 1);
  localparam logic [CW-1:0] L_PWR = CW'(PWR_CYC - 1);
  localparam logic [CW-1:0] L_REFI = CW'(REFI_CYC - 1);
  localparam logic [3:0] L_INIT_REF = 4'(`INIT_REF_COUNT);
  localparam logic [`ADDR_W-1:0] ALL_BANKS = `ADDR_W'(1) << `ADDR_AP_BIT;

  sdram_guard_pkg::state_t state, next_state;
  sdram_guard_pkg::pin_cmd_t cmd, next_cmd;
  logic [CW-1:0] wait_cnt, next_wait, refi, next_refi, rrd, next_rrd;
  logic [3:0] ref_left, next_ref_left;
  logic ref_pend, next_ref_pend, cke, next_cke, ba, next_ba;
  logic [`ADDR_W-1:0] addr, next_addr;
  logic [`DQ_W-1:0] dq, next_dq, rd_data, next_rd_data, dq_s1, dq_s2;
  logic dq_oe_b, next_dq_oe_b, rd_valid, next_rd_valid;
  logic [1:0] dqm, next_dqm;
  logic [TAP:0] rd_pipe, next_rd_pipe;
  logic [1:0] ev_act, ev_col, ev_ap, ev_pre, b_open, b_act_ok, b_col_ok;
  logic [1:0] b_pre_ok, b_close;
  logic ev_wr, legal, ready, issue_rd, ap;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_bank
      bank_tracker #(
        .TRC(TRC_C), .TRAS(`T_RAS_CYC), .TRP(`T_RP_CYC), .TRCD(`T_RCD_CYC),
        .TDPL(`T_DPL_CYC), .TDAL(`T_DAL_CYC), .RAS_MAX(RAS_MAX_CYC), .CW(CW)
      ) u_bank (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_act(ev_act[g]),
        .i_col(ev_col[g]),
        .i_wr(ev_wr),
        .i_ap(ev_ap[g]),
        .i_pre(ev_pre[g]),
        .o_open(b_open[g]),
        .o_act_ok(b_act_ok[g]),
        .o_col_ok(b_col_ok[g]),
        .o_pre_ok(b_pre_ok[g]),
        .o_must_close(b_close[g])
      );
    end
  endgenerate

  assign ap = i_req_addr[`ADDR_AP_BIT];

  always_comb begin
    legal = 1'b0;
    case (i_req_op)
      sdram_guard_pkg::OP_ACT:
        legal = !b_open[i_req_bank] && b_act_ok[i_req_bank] && rrd == '0;
      sdram_guard_pkg::OP_RD, sdram_guard_pkg::OP_WR:
        legal = b_col_ok[i_req_bank] && (!ap || b_pre_ok[i_req_bank]);
      sdram_guard_pkg::OP_PRE:
        legal = ap ? &b_pre_ok : b_pre_ok[i_req_bank];
      default: legal = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_wait = (wait_cnt == '0) ? wait_cnt : wait_cnt - 1'b1;
    next_ref_left = ref_left;
    next_refi = refi;
    next_rrd = (rrd == '0) ? rrd : rrd - 1'b1;
    next_cke = cke;
    next_cmd = sdram_guard_pkg::PIN_NOP;
    next_addr = addr;
    next_ba = ba;
    next_dq = dq;
    next_dq_oe_b = 1'b1;
    next_dqm = 2'b00;
    ev_act = 2'b00;
    ev_col = 2'b00;
    ev_ap = 2'b00;
    ev_pre = 2'b00;
    ev_wr = 1'b0;
    ready = 1'b0;
    issue_rd = 1'b0;
    if (state == sdram_guard_pkg::ST_RUN)
      next_refi = (refi == '0) ? L_REFI : refi - 1'b1;
    next_ref_pend = ref_pend;
    case (state)
      sdram_guard_pkg::ST_PWR: begin
        if (wait_cnt == '0) begin
          next_cke = 1'b1;
          next_wait = L_CKA;
          next_state = sdram_guard_pkg::ST_CKE;
        end
      end
      sdram_guard_pkg::ST_CKE: begin
        if (wait_cnt == '0) begin
          next_cmd = sdram_guard_pkg::PIN_PRE;
          next_addr = ALL_BANKS;
          ev_pre = 2'b11;
          next_wait = L_RP;
          next_state = sdram_guard_pkg::ST_IREF;
        end
      end
      sdram_guard_pkg::ST_IREF: begin
        if (wait_cnt == '0) begin
          next_cmd = sdram_guard_pkg::PIN_REF;
          next_wait = L_RC;
          next_ref_left = ref_left - 1'b1;
          if (ref_left == 4'h1)
            next_state = sdram_guard_pkg::ST_MRS;
        end
      end
      sdram_guard_pkg::ST_MRS: begin
        if (wait_cnt == '0) begin
          next_cmd = sdram_guard_pkg::PIN_MRS;
          next_addr = `MODE_WORD;
          next_ba = 1'b0;
          next_wait = L_MRD;
          next_state = sdram_guard_pkg::ST_RUN;
        end
      end
      sdram_guard_pkg::ST_RUN: begin
        if (wait_cnt != '0) begin
          next_cmd = sdram_guard_pkg::PIN_NOP;
        end else if (ref_pend || |b_close) begin
          if (|b_open) begin
            if (&b_pre_ok) begin
              next_cmd = sdram_guard_pkg::PIN_PRE;
              next_addr = ALL_BANKS;
              ev_pre = 2'b11;
            end
          end else if (ref_pend && &b_act_ok) begin
            next_cmd = sdram_guard_pkg::PIN_REF;
            next_wait = L_RC;
            next_ref_pend = 1'b0;
          end
        end else if (i_req_valid && legal && i_ce) begin
          ready = 1'b1;
          next_addr = i_req_addr;
          next_ba = i_req_bank;
          case (i_req_op)
            sdram_guard_pkg::OP_ACT: begin
              next_cmd = sdram_guard_pkg::PIN_ACT;
              ev_act[i_req_bank] = 1'b1;
              next_rrd = L_RRD;
            end
            sdram_guard_pkg::OP_RD: begin
              next_cmd = sdram_guard_pkg::PIN_RD;
              ev_col[i_req_bank] = 1'b1;
              ev_ap[i_req_bank] = ap;
              issue_rd = 1'b1;
            end
            sdram_guard_pkg::OP_WR: begin
              next_cmd = sdram_guard_pkg::PIN_WR;
              ev_col[i_req_bank] = 1'b1;
              ev_ap[i_req_bank] = ap;
              ev_wr = 1'b1;
              next_dq = i_req_wdata;
              next_dq_oe_b = 1'b0;
              next_dqm = i_req_wmask;
            end
            sdram_guard_pkg::OP_PRE: begin
              next_cmd = sdram_guard_pkg::PIN_PRE;
              if (ap)
                ev_pre = 2'b11;
              else
                ev_pre[i_req_bank] = 1'b1;
            end
            default: next_cmd = sdram_guard_pkg::PIN_NOP;
          endcase
        end
      end
      default: next_state = sdram_guard_pkg::ST_PWR;
    endcase
    // a due refresh is never lost to a clear in the same cycle
    if (state == sdram_guard_pkg::ST_RUN && refi == '0)
      next_ref_pend = 1'b1;
    next_rd_pipe = {rd_pipe[TAP-1:0], issue_rd};
    next_rd_valid = rd_pipe[TAP];
    next_rd_data = rd_pipe[TAP] ? dq_s2 : rd_data;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= sdram_guard_pkg::ST_PWR;
      wait_cnt <= L_PWR;
      ref_left <= L_INIT_REF;
      refi <= L_REFI;
      ref_pend <= 1'b0;
      rrd <= '0;
      cke <= 1'b0;
      cmd <= sdram_guard_pkg::PIN_NOP;
      addr <= '0;
      ba <= 1'b0;
      dq <= '0;
      dq_oe_b <= 1'b1;
      dqm <= 2'b00;
      rd_pipe <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else if (i_ce) begin
      state <= next_state;
      wait_cnt <= next_wait;
      ref_left <= next_ref_left;
      refi <= next_refi;
      ref_pend <= next_ref_pend;
      rrd <= next_rrd;
      cke <= next_cke;
      cmd <= next_cmd;
      addr <= next_addr;
      ba <= next_ba;
      dq <= next_dq;
      dq_oe_b <= next_dq_oe_b;
      dqm <= next_dqm;
      rd_pipe <= next_rd_pipe;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
    end
  end

  assign o_req_ready = ready;
  assign o_init_done = state == sdram_guard_pkg::ST_RUN;
  assign o_rd_valid = rd_valid;
  assign o_rd_data = rd_data;
  assign o_cke = cke;
  assign {o_cs_b, o_ras_b, o_cas_b, o_we_b} = cmd;
  assign o_addr = addr;
  assign o_bank_address_bit = ba;
  assign o_dqm = dqm;
  assign o_dq = dq;
  assign o_dq_oe_b = dq_oe_b;

  // cycles since last activate, refresh, mode load, cke rise, reset
  logic [CW-1:0] h_act, h_ref, h_mrs, h_cke, h_up;
  logic any_cmd;
  assign any_cmd = next_cmd != sdram_guard_pkg::PIN_NOP;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      h_act <= '1;
      h_ref <= '1;
      h_mrs <= '1;
      h_cke <= '0;
      h_up <= '0;
    end else if (i_ce) begin
      h_act <= (|ev_act) ? CW'(1) : (h_act == '1 ? h_act : h_act + 1'b1);
      h_ref <= (next_cmd == sdram_guard_pkg::PIN_REF) ? CW'(1) :
               (h_ref == '1 ? h_ref : h_ref + 1'b1);
      h_mrs <= (next_cmd == sdram_guard_pkg::PIN_MRS) ? CW'(1) :
               (h_mrs == '1 ? h_mrs : h_mrs + 1'b1);
      h_cke <= (next_cke && !cke) ? CW'(1) :
               (h_cke == '1 ? h_cke : h_cke + 1'b1);
      h_up <= (h_up == '1) ? h_up : h_up + 1'b1;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  AST_TRRD: assert property (
    i_ce && |ev_act |-> h_act >= CW'(TRRD_C))
    else $error("activates to the two banks too close");
  AST_REF_QUIET: assert property (
    i_ce && any_cmd |-> h_ref >= CW'(TRC_C))
    else $error("command issued during refresh row cycle");
  AST_MRS_QUIET: assert property (
    i_ce && any_cmd |-> h_mrs >= CW'(TMRD_C))
    else $error("command issued too soon after mode load");
  AST_CKE_REC: assert property (
    i_ce && any_cmd |-> cke && h_cke >= CW'(TCKA_C))
    else $error("command too soon after clock enable rise");
  AST_PWR_WAIT: assert property (
    i_ce && next_cke && !cke |-> h_up >= CW'(PWR_CYC - 1))
    else $error("power-up wait cut short");
  AST_INIT_FIRST: assert property (
    i_ce && (|ev_act || |ev_col) |-> state == sdram_guard_pkg::ST_RUN
      && h_mrs >= CW'(TMRD_C))
    else $error("memory access before initialization");
  AST_REFI: assert property (
    state == sdram_guard_pkg::ST_RUN |-> h_ref < CW'(REFI_CYC + 32))
    else $error("refresh interval exceeded");
  AST_PALL: assert property (
    i_ce && next_cmd == sdram_guard_pkg::PIN_PRE && next_addr[`ADDR_AP_BIT]
      |=> b_open == 2'b00)
    else $error("precharge all left a bank open");

  COV_REFRESH: cover property (
    i_ce && next_cmd == sdram_guard_pkg::PIN_REF && o_init_done);
  COV_WRITE_AP: cover property (i_ce && ev_wr && |ev_ap);
  COV_READ_DATA: cover property (rd_valid);
  COV_FORCED_CLOSE: cover property (|b_close ##[1:16] b_open == 2'b00);
endmodule

// ===== shared/sdram_timing_defs.svh
// timing, field and reset constants for the sdram command guard
`ifndef SDRAM_TIMING_DEFS_SVH
`define SDRAM_TIMING_DEFS_SVH

`define CLK_PERIOD_PS 40000
`define CEIL_CYC(ns) ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FLOOR_CYC(ns) (((ns) * 1000) / `CLK_PERIOD_PS)

`define T_RC_NS 70
`define T_RAS_MIN_NS 50
`define T_RAS_MAX_NS 100000
`define T_RP_NS 20
`define T_RCD_NS 20
`define T_RRD_NS 20
`define T_CKA_EXTRA_NS 3
`define T_PWR_US 100
`define T_REF_MS 64
`define REF_ROWS 4096
`define T_REFI_NS ((`T_REF_MS * 1000000) / `REF_ROWS)

`define T_RC_CYC `CEIL_CYC(`T_RC_NS)
`define T_RAS_CYC `CEIL_CYC(`T_RAS_MIN_NS)
`define T_RAS_MAX_CYC `FLOOR_CYC(`T_RAS_MAX_NS)
`define T_RP_CYC `CEIL_CYC(`T_RP_NS)
`define T_RCD_CYC `CEIL_CYC(`T_RCD_NS)
`define T_RRD_CYC `CEIL_CYC(`T_RRD_NS)
`define T_CKA_CYC (1 + `CEIL_CYC(`T_CKA_EXTRA_NS))
`define T_PWR_CYC `CEIL_CYC(`T_PWR_US * 1000)
`define T_REFI_CYC `FLOOR_CYC(`T_REFI_NS)
`define T_DPL_CYC 1
`define T_DAL_CYC (1 + `T_RP_CYC)
`define T_MRD_CYC 2

`define RAS_CLOSE_MARGIN 16
`define CAS_LAT 3
`define RD_TAP (`CAS_LAT + 2)
`define INIT_REF_COUNT 2
`define CNT_W 12
`define ADDR_W 11
`define ADDR_AP_BIT 10
`define MODE_WORD 11'h030
`define DQ_W 16

`endif

// ===== shared/sdram_guard_pkg.sv
// types shared by the sdram command guard
package sdram_guard_pkg;

  // {cs_b, ras_b, cas_b, we_b}
  typedef enum logic [3:0] {
    PIN_MRS = 4'h0,
    PIN_REF = 4'h1,
    PIN_PRE = 4'h2,
    PIN_ACT = 4'h3,
    PIN_WR = 4'h4,
    PIN_RD = 4'h5,
    PIN_NOP = 4'h7
  } pin_cmd_t;

  typedef enum logic [1:0] {
    OP_ACT = 2'h0,
    OP_RD = 2'h1,
    OP_WR = 2'h2,
    OP_PRE = 2'h3
  } req_op_t;

  typedef enum logic [4:0] {
    ST_PWR = 5'h01,
    ST_CKE = 5'h02,
    ST_IREF = 5'h04,
    ST_MRS = 5'h08,
    ST_RUN = 5'h10
  } state_t;

endpackage

// ===== rtl/bank_tracker.sv
// per-bank open state and spacing timers
`timescale 1ns/1ps
`include "sdram_timing_defs.svh"
module bank_tracker #(
  parameter int TRC = 2,
  parameter int TRAS = 2,
  parameter int TRP = 1,
  parameter int TRCD = 1,
  parameter int TDPL = 1,
  parameter int TDAL = 2,
  parameter int RAS_MAX = 2500,
  parameter int CW = 12
) (
  input wire logic i_ref_clk,     // system clock
  input wire logic i_rst_b,       // async reset, active low
  input wire logic i_ce,          // clock enable
  input wire logic i_act,         // activate to this bank
  input wire logic i_col,         // read or write to this bank
  input wire logic i_wr,          // column command is a write
  input wire logic i_ap,          // column command auto-precharges
  input wire logic i_pre,         // precharge to this bank
  output logic o_open,            // row open
  output logic o_act_ok,          // activate allowed
  output logic o_col_ok,          // read or write allowed
  output logic o_pre_ok,          // precharge allowed
  output logic o_must_close       // open time near its limit
);
  localparam logic [CW-1:0] L_RC = CW'(TRC - 1);
  localparam logic [CW-1:0] L_RAS = CW'(TRAS - 1);
  localparam logic [CW-1:0] L_RP = CW'(TRP - 1);
  localparam logic [CW-1:0] L_RCD = CW'(TRCD - 1);
  localparam logic [CW-1:0] L_DPL = CW'(TDPL - 1);
  localparam logic [CW-1:0] L_DAL = CW'(TDAL - 1);
  localparam logic [CW-1:0] L_MAX = CW'(RAS_MAX);
  localparam logic [CW-1:0] L_CLOSE = CW'(RAS_MAX - `RAS_CLOSE_MARGIN);

  logic open, next_open;
  logic [CW-1:0] rc, ras, rp, rcd, dpl, age;
  logic [CW-1:0] next_rc, next_ras, next_rp, next_rcd, next_dpl, next_age;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction

  always_comb begin
    next_open = open;
    next_rc = dec(rc);
    next_ras = dec(ras);
    next_rp = dec(rp);
    next_rcd = dec(rcd);
    next_dpl = dec(dpl);
    next_age = (open && age != L_MAX) ? age + 1'b1 : age;
    if (i_act) begin
      next_open = 1'b1;
      next_rc = L_RC;
      next_ras = L_RAS;
      next_rcd = L_RCD;
      next_age = '0;
    end
    if (i_col && i_wr)
      next_dpl = L_DPL;
    if (i_col && i_ap) begin
      next_open = 1'b0;
      next_rp = i_wr ? L_DAL : L_RP;
    end
    if (i_pre && open) begin
      next_open = 1'b0;
      next_rp = L_RP;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      open <= 1'b0;
      rc <= '0;
      ras <= '0;
      rp <= '0;
      rcd <= '0;
      dpl <= '0;
      age <= '0;
    end else if (i_ce) begin
      open <= next_open;
      rc <= next_rc;
      ras <= next_ras;
      rp <= next_rp;
      rcd <= next_rcd;
      dpl <= next_dpl;
      age <= next_age;
    end
  end

  assign o_open = open;
  assign o_act_ok = !open && rc == '0 && rp == '0;
  assign o_col_ok = open && rcd == '0;
  assign o_pre_ok = !open || (ras == '0 && dpl == '0);
  assign o_must_close = open && age >= L_CLOSE;

  // cycles since last activate, precharge and write
  logic [CW-1:0] h_act, h_pre, h_wr, h_need;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      h_act <= '1;
      h_pre <= '1;
      h_wr <= '1;
      h_need <= '0;
    end else if (i_ce) begin
      h_act <= i_act ? CW'(1) : (h_act == '1 ? h_act : h_act + 1'b1);
      h_pre <= ((i_pre && open) || (i_col && i_ap)) ? CW'(1) :
               (h_pre == '1 ? h_pre : h_pre + 1'b1);
      h_wr <= (i_col && i_wr) ? CW'(1) : (h_wr == '1 ? h_wr : h_wr + 1'b1);
      if (i_pre && open)
        h_need <= CW'(TRP);
      else if (i_col && i_ap)
        h_need <= i_wr ? CW'(TDAL) : CW'(TRP);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  AST_TRC: assert property (
    i_ce && i_act |-> h_act >= CW'(TRC))
    else $error("same-bank activates closer than row cycle");
  AST_TRAS_MIN: assert property (
    i_ce && ((i_pre && open) || (i_col && i_ap)) |-> h_act >= CW'(TRAS))
    else $error("precharge too soon after activate");
  AST_TRP: assert property (
    i_ce && i_act |-> h_pre >= h_need)
    else $error("activate too soon after precharge");
  AST_TRCD: assert property (
    i_ce && i_col |-> open && h_act >= CW'(TRCD))
    else $error("column command too soon after activate");
  AST_TDPL: assert property (
    i_ce && i_pre && open |-> h_wr >= CW'(TDPL))
    else $error("precharge too soon after write data");
  AST_TRAS_MAX: assert property (
    o_must_close |-> ##[1:16] !open)
    else $error("row left open past its limit");
endmodule

// ===== verif/sdram_device_model.sv
// behavioural two-bank sdram that counts command spacing faults
`timescale 1ns/1ps
module sdram_device_model #(
  parameter int REFI = 60,
  parameter int RAS_MAX = 40
) (
  input wire logic i_clk,          // system clock
  input wire logic i_cke,          // clock enable pin
  input wire logic [3:0] i_cmd,    // cs_b ras_b cas_b we_b
  input wire logic [10:0] i_addr,  // address pins
  input wire logic i_ba,           // bank select pin
  input wire logic [1:0] i_dqm,    // byte masks
  input wire logic [15:0] i_dq,    // write data from controller
  output logic [15:0] o_dq,        // read data to controller
  output logic [7:0] o_err,        // spacing faults seen
  output logic [7:0] o_refs        // refreshes seen
);
  localparam int TRC = 2, TRAS = 2, TCKA = 2, TMRD = 2;
  int cyc = 0, ck = 0, ref_t = -99, mrs_t = -99;
  int act_t[2] = '{-99, -99};
  int pre_t[2] = '{-99, -99};
  logic open_b[2] = '{1'b0, 1'b0};
  logic rd_p[2] = '{1'b0, 1'b0};
  logic init_ok = 1'b0;
  logic [8:0] ra[2];
  // rows are not modelled: one word per bank and column
  logic [15:0] mem [0:511];
  initial begin
    o_err = 8'h00;
    o_refs = 8'h00;
    o_dq = 16'h5a5a;
  end
  task automatic fault();
    o_err = o_err + 8'h01;
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    ck = i_cke ? ck + 1 : 0;
    // cas latency 3; idle bus toggles so stale data never matches
    o_dq <= rd_p[1] ? mem[ra[1]] : ~o_dq;
    rd_p[1] = rd_p[0];
    ra[1] = ra[0];
    rd_p[0] = 1'b0;
    if (i_cke === 1'b1 && i_cmd[3] === 1'b0 && i_cmd != 4'h7) begin
      if (ck < TCKA) fault();
      if (cyc - mrs_t < TMRD) fault();
      if (cyc - ref_t < TRC) fault();
      case (i_cmd)
        sdram_guard_pkg::PIN_ACT: begin
          if (!init_ok || open_b[i_ba]) fault();
          if (cyc - act_t[i_ba] < TRC) fault();
          if (cyc - pre_t[i_ba] < 1) fault();
          if (cyc - act_t[!i_ba] < 1) fault();
          open_b[i_ba] = 1'b1;
          act_t[i_ba] = cyc;
        end
        sdram_guard_pkg::PIN_RD, sdram_guard_pkg::PIN_WR: begin
          if (!open_b[i_ba] || cyc - act_t[i_ba] < 1) fault();
          if (i_cmd == sdram_guard_pkg::PIN_WR) begin
            if (!i_dqm[0]) mem[{i_ba, i_addr[7:0]}][7:0] = i_dq[7:0];
            if (!i_dqm[1]) mem[{i_ba, i_addr[7:0]}][15:8] = i_dq[15:8];
          end else begin
            rd_p[0] = 1'b1;
            ra[0] = {i_ba, i_addr[7:0]};
          end
          if (i_addr[10]) begin
            if (cyc - act_t[i_ba] < TRAS) fault();
            open_b[i_ba] = 1'b0;
            pre_t[i_ba] = cyc + (i_cmd == sdram_guard_pkg::PIN_WR);
          end
        end
        sdram_guard_pkg::PIN_PRE: begin
          for (int i = 0; i < 2; i++) begin
            if (i_addr[10] || i == int'(i_ba)) begin
              if (open_b[i] && cyc - act_t[i] < TRAS) fault();
              open_b[i] = 1'b0;
              pre_t[i] = cyc;
            end
          end
        end
        sdram_guard_pkg::PIN_REF: begin
          if (open_b[0] || open_b[1]) fault();
          ref_t = cyc;
          o_refs = o_refs + 8'h01;
        end
        sdram_guard_pkg::PIN_MRS: begin
          mrs_t = cyc;
          init_ok = 1'b1;
        end
        default: fault();
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      if (open_b[i] && cyc - act_t[i] > RAS_MAX) fault();
    end
    if (init_ok && cyc - ref_t > REFI + 8) fault();
  end
endmodule

// ===== verif/sdram_command_timing_guard_bench.sv
// bench for the sdram command timing guard
`timescale 1ns/1ps
module sdram_command_timing_guard_bench;
  localparam int PWR = 20, REFI = 60, RASM = 40;
  localparam logic [1:0] ACT = 2'h0, RD = 2'h1, WR = 2'h2, PRE = 2'h3;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_req_valid = 1'b0;
  sdram_guard_pkg::req_op_t i_req_op = sdram_guard_pkg::OP_ACT;
  logic i_req_bank = 1'b0, o_req_ready, o_init_done, o_rd_valid, o_cke;
  logic o_cs_b, o_ras_b, o_cas_b, o_we_b, o_bank_address_bit, o_dq_oe_b;
  logic [10:0] i_req_addr = 11'h000, o_addr;
  logic [15:0] i_req_wdata = 16'h0000, o_rd_data, o_dq, i_dq;
  logic [1:0] i_req_wmask = 2'h0, o_dqm;
  logic [7:0] err, refs, r0;
  int n_mismatch = 0, tests_run = 0;
  time t0;
  always #20 i_ref_clk = ~i_ref_clk;
  sdram_command_timing_guard #(.PWR_CYC(PWR), .REFI_CYC(REFI),
    .RAS_MAX_CYC(RASM)) dut_u (.i_ref_clk, .i_rst_b, .i_ce, .i_req_valid,
    .i_req_op, .i_req_bank, .i_req_addr, .i_req_wdata, .i_req_wmask,
    .o_req_ready, .o_init_done, .o_rd_valid, .o_rd_data, .o_cke, .o_cs_b,
    .o_ras_b, .o_cas_b, .o_we_b, .o_addr, .o_bank_address_bit, .o_dqm,
    .o_dq, .o_dq_oe_b, .i_dq);
  sdram_device_model #(.REFI(REFI), .RAS_MAX(RASM)) mdl_u (
    .i_clk(i_ref_clk), .i_cke(o_cke),
    .i_cmd({o_cs_b, o_ras_b, o_cas_b, o_we_b}), .i_addr(o_addr),
    .i_ba(o_bank_address_bit), .i_dqm(o_dqm), .i_dq(o_dq), .o_dq(i_dq),
    .o_err(err), .o_refs(refs));
  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      $display("BAD %0t %s", $time, m);
      n_mismatch++;
    end
  endtask
  // holds the request until taken; returns at the taking edge
  task automatic req(input logic [1:0] op, input logic b,
                     input logic [10:0] a, input logic [15:0] d = 16'h0000,
                     input logic [1:0] m = 2'h0);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    i_req_valid = 1'b1;
    i_req_op = sdram_guard_pkg::req_op_t'(op);
    i_req_bank = b;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_wmask = m;
    #1;
    while (o_req_ready !== 1'b1 && n < 300) begin
      @(negedge i_ref_clk);
      #1;
      n++;
    end
    if (n == 300) begin
      chk(1'b0, "request never taken");
      test_done();
    end
    @(posedge i_ref_clk);
  endtask
  task automatic idle(input int c);
    @(negedge i_ref_clk);
    i_req_valid = 1'b0;
    repeat (c) @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic b, input logic [10:0] a,
                    input logic [15:0] e);
    req(RD, b, a);
    idle(5);
    #1;
    chk(o_rd_valid === 1'b0, "read pulse early");
    @(posedge i_ref_clk);
    #1;
    chk(o_rd_valid === 1'b1 && o_rd_data === e, "read data wrong");
  endtask
  task automatic t_init();
    int n;
    n = 0;
    while (o_cke !== 1'b1 && n < 500) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk(o_cke === 1'b1 && n >= PWR, "clock enable timing wrong");
    n = 0;
    while (o_init_done !== 1'b1 && n < 50) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk(o_init_done === 1'b1 && refs >= 8'h01, "init incomplete");
  endtask
  task automatic t_wr_rd();
    req(ACT, 1'b0, 11'h005);
    t0 = $time;
    req(WR, 1'b0, 11'h003, 16'ha5c3);
    req(PRE, 1'b0, 11'h000);
    chk($time - t0 >= 80, "precharge too soon after activate");
    req(ACT, 1'b0, 11'h005);
    req(WR, 1'b0, 11'h003, 16'h1111, 2'h2);
    rd(1'b0, 11'h003, 16'ha511);
    req(PRE, 1'b0, 11'h000);
  endtask
  task automatic t_banks();
    req(ACT, 1'b0, 11'h010);
    req(ACT, 1'b1, 11'h020);
    req(WR, 1'b1, 11'h007, 16'h3c3c);
    req(WR, 1'b0, 11'h007, 16'hc3c3);
    req(PRE, 1'b0, 11'h400);
    req(ACT, 1'b1, 11'h021);
    req(ACT, 1'b0, 11'h011);
    rd(1'b1, 11'h007, 16'h3c3c);
    rd(1'b0, 11'h007, 16'hc3c3);
    req(PRE, 1'b0, 11'h400);
  endtask
  task automatic t_ap();
    req(ACT, 1'b1, 11'h030);
    req(WR, 1'b1, 11'h408, 16'h0f0f);
    t0 = $time;
    req(ACT, 1'b1, 11'h031);
    chk($time - t0 >= 80, "activate inside write recovery");
    rd(1'b1, 11'h408, 16'h0f0f);
    req(ACT, 1'b1, 11'h032);
    req(PRE, 1'b1, 11'h000);
  endtask
  task automatic t_refresh();
    req(ACT, 1'b0, 11'h033);
    r0 = refs;
    idle(4 * REFI);
    chk(refs - r0 >= 8'h03, "refresh quota missed");
    req(ACT, 1'b0, 11'h034);
    req(PRE, 1'b0, 11'h400);
    idle(4);
    // row left open must be closed by the guard before its limit
    req(ACT, 1'b1, 11'h035);
    idle(RASM);
  endtask
  initial begin
    repeat (6) @(posedge i_ref_clk);
    chk(o_cke === 1'b0, "clock enable high in reset");
    @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    t_init();
    t_wr_rd();
    t_banks();
    t_ap();
    t_refresh();
    chk(err === 8'h00, "device saw a spacing fault");
    test_done();
  end
endmodule
